// ---- common/qsend_pkg.sv ----
package qsend_pkg;
   // link opcodes and fields
   localparam logic [7:0] CMD_SEND_QUEUED = 8'h64;
   localparam logic [4:0] SUB_LOG_WRITE = 5'h02;
   localparam int SUB_MSB = 4;
   localparam int TAG_LSB = 3;
   localparam int TAG_W = 5;
   localparam int TAGS = 32;
   localparam int BUF_DEPTH = 2;
   // flag bits carried back in a register frame
   localparam logic [7:0] STAT_RDY = 8'h40;
   localparam logic [7:0] STAT_ERR = 8'h01;
   localparam logic [7:0] ERR_ABT = 8'h04;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   // host register map, byte addresses
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_COUNT = 8'h04;
   localparam logic [7:0] A_TAG = 8'h08;
   localparam logic [7:0] A_LBA_LO = 8'h0C;
   localparam logic [7:0] A_LBA_HI = 8'h10;
   localparam logic [7:0] A_ISSUE = 8'h14;
   localparam logic [7:0] A_RESULT = 8'h18;
   localparam logic [7:0] A_DONE = 8'h1C;
   localparam int COUNT_SUB_LSB = 16;
   localparam int RESULT_BUSY_BIT = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] feat_cur;
      logic [7:0] feat_prev;
      logic [7:0] cnt_cur;
      logic [7:0] cnt_prev;
      logic [7:0] sn_cur;
      logic [7:0] sn_prev;
      logic [7:0] cl_cur;
      logic [7:0] cl_prev;
      logic [7:0] ch_cur;
      logic [7:0] ch_prev;
   } h2d_frame_t;

   typedef enum logic [0:0] {FR_REG = 1'b0, FR_SDB = 1'b1} frame_kind_t;

   typedef struct packed {
      frame_kind_t kind;
      logic [7:0] status;
      logic [7:0] error;
      logic [TAGS-1:0] act;
   } d2h_frame_t;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic [15:0] count;
      logic [47:0] lba;
   } log_write_t;

   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_REPLY = 1'b1} dev_state_t;
endpackage

// ---- common/qsend_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface qsend_if
   import qsend_pkg::*;
(
   input wire logic aclk
);
   logic h2d_valid;
   logic h2d_ready;
   h2d_frame_t h2d;
   logic d2h_valid;
   logic d2h_ready;
   d2h_frame_t d2h;

   modport host_end
   (
      output h2d_valid,
      output h2d,
      input h2d_ready,
      input d2h_valid,
      input d2h,
      output d2h_ready
   );

   modport device_end
   (
      input h2d_valid,
      input h2d,
      output h2d_ready,
      output d2h_valid,
      output d2h,
      input d2h_ready
   );
endinterface
`default_nettype wire

// ---- logic/qsend_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsend_device
   import qsend_pkg::*;
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // link to host
   qsend_if.device_end lnk,
   // accepted log writes toward the data engine
   output logic wr_valid,
   input wire logic wr_ready,
   output log_write_t wr_item,
   // completions from the data engine
   input wire logic done_valid,
   input wire logic [TAG_W-1:0] done_tag,
   // last flags sent in a register frame
   output logic [7:0] command_error_flags,
   output logic [7:0] command_status_flags
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      dev_state_t fsm;
      logic h2d_ready;
      logic d2h_valid;
      d2h_frame_t d2h;
      // finishes gathered since the last set-bits frame
      logic [TAGS-1:0] pend;
      // tags accepted and not yet finished by the data engine
      logic [TAGS-1:0] busy_tags;
      logic [1:0] cnt;
      logic wr_valid;
      log_write_t [BUF_DEPTH-1:0] ent;
      logic [7:0] err;
      logic [7:0] stat;
   } dev_t;

   localparam dev_t DEV_RESET = '{
      fsm: ST_IDLE,
      h2d_ready: 1'b0,
      d2h_valid: 1'b0,
      d2h: '0,
      pend: '0,
      busy_tags: '0,
      cnt: 2'h0,
      wr_valid: 1'b0,
      ent: '0,
      err: FLAGS_RESET,
      stat: FLAGS_RESET
   };

   dev_t r_reg;
   dev_t r_next;

   ////////////////////////////////////////////////////////////////////////////////
   // decode of the incoming shadow bytes
   // count bits 4:0 share the feature byte with the subcommand
   h2d_frame_t f;
   log_write_t item;
   logic cmd_ok;
   logic sub_ok;
   logic tag_free;

   always_comb
   begin
      f = lnk.h2d;
      item.tag = f.cnt_cur[TAG_LSB +: TAG_W];
      item.count = {f.feat_prev, f.feat_cur};
      item.lba = {f.ch_prev, f.cl_prev, f.sn_prev,
                  f.ch_cur, f.cl_cur, f.sn_cur};
      cmd_ok = (f.cmd == CMD_SEND_QUEUED);
      sub_ok = (f.feat_cur[SUB_MSB:0] == SUB_LOG_WRITE);
      // a reused live tag would merge two completions into one bit
      tag_free = !r_reg.busy_tags[item.tag];
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic take;
   logic pop;

   always_comb
   begin
      r_next = r_reg;
      take = lnk.h2d_valid && r_reg.h2d_ready;
      pop = (r_reg.cnt != 2'h0) && wr_ready;

      // two-entry buffer, head always in entry 0
      // pop first, so a same-cycle push lands in entry 0 as the new head
      if (pop)
      begin
         r_next.ent[0] = r_reg.ent[1];
         r_next.cnt = r_reg.cnt - 2'h1;
      end

      case (r_reg.fsm)
         ST_IDLE:
         begin
            // a command reply goes before a waiting set-bits frame
            if (take)
            begin
               if (cmd_ok && sub_ok && tag_free)
               begin
                  r_next.ent[r_next.cnt[0]] = item;
                  r_next.cnt = r_next.cnt + 2'h1;
                  r_next.busy_tags[item.tag] = 1'b1;
                  // acceptance: busy stays clear, no error
                  r_next.stat = STAT_RDY;
                  r_next.err = FLAGS_RESET;
               end
               else
               begin
                  // nothing is queued and the tag's busy bit is left as it was
                  r_next.stat = STAT_RDY | STAT_ERR;
                  r_next.err = ERR_ABT;
               end
               r_next.d2h.kind = FR_REG;
               r_next.d2h.status = r_next.stat;
               r_next.d2h.error = r_next.err;
               r_next.d2h.act = '0;
               r_next.d2h_valid = 1'b1;
               r_next.fsm = ST_REPLY;
            end
            else if (r_reg.pend != '0)
            begin
               // report and clear together; a finish now waits for the next frame
               r_next.d2h.kind = FR_SDB;
               r_next.d2h.status = STAT_RDY;
               r_next.d2h.error = FLAGS_RESET;
               r_next.d2h.act = r_reg.pend;
               r_next.pend = '0;
               r_next.d2h_valid = 1'b1;
               r_next.fsm = ST_REPLY;
            end
         end
         ST_REPLY:
         begin
            // a stalled reply holds its frame unchanged
            if (lnk.d2h_ready)
            begin
               r_next.d2h_valid = 1'b0;
               r_next.fsm = ST_IDLE;
            end
         end
         default:
         begin
            // unused code: drop the frame and return to idle
            r_next.fsm = ST_IDLE;
            r_next.d2h_valid = 1'b0;
         end
      endcase

      // a finish for a tag that is not live is dropped
      // completion after the clear, so a same-cycle finish is kept
      if (done_valid && r_reg.busy_tags[done_tag])
      begin
         r_next.pend[done_tag] = 1'b1;
         r_next.busy_tags[done_tag] = 1'b0;
      end

      // stall the host while replying or with no room for a word
      r_next.h2d_ready = (r_next.fsm == ST_IDLE) && (r_next.cnt < 2'h2);

      // buffer valid kept as a flop rather than a compare
      r_next.wr_valid = (r_next.cnt != 2'h0);
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // frames in flight are dropped, ready comes back a cycle later
         r_reg <= DEV_RESET;
      end
      else if (ce)
      begin
         // ce low freezes every field, handshakes included
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // every output straight from the state register
   assign lnk.h2d_ready = r_reg.h2d_ready;
   assign lnk.d2h_valid = r_reg.d2h_valid;
   assign lnk.d2h = r_reg.d2h;
   assign wr_valid = r_reg.wr_valid;
   assign wr_item = r_reg.ent[0];
   assign command_error_flags = r_reg.err;
   assign command_status_flags = r_reg.stat;

endmodule
`default_nettype wire

// ---- logic/qsend_host.sv ----
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module qsend_host
   import qsend_pkg::*;
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // link to device
   qsend_if.host_end lnk,
   // axi4-lite write
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] cmd;
      logic [31:0] count;
      logic [31:0] tag;
      logic [31:0] lba_lo;
      logic [31:0] lba_hi;
      logic [31:0] done;
      logic [7:0] stat;
      logic [7:0] err;
      logic h2d_valid;
      h2d_frame_t h2d;
   } host_t;

   localparam host_t HOST_RESET = '{cmd: {24'h000000, CMD_SEND_QUEUED}, default: '0};

   host_t r_reg;
   host_t r_next;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
         begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] cnt16;
   logic [47:0] lba;

   always_comb
   begin
      r_next = r_reg;
      cnt16 = r_reg.count[15:0];
      lba = {r_reg.lba_hi[15:0], r_reg.lba_lo};
      if (s_awvalid && !r_reg.aw_have)
      begin
         r_next.aw_have = 1'b1;
         r_next.aw_addr = s_awaddr;
      end
      if (s_wvalid && !r_reg.w_have)
      begin
         r_next.w_have = 1'b1;
         r_next.w_data = s_wdata;
         r_next.w_strb = s_wstrb;
      end
      if (r_reg.bvalid && s_bready)
      begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.h2d_valid && lnk.h2d_ready)
      begin
         r_next.h2d_valid = 1'b0;
      end
      if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid)
      begin
         r_next.aw_have = 1'b0;
         r_next.w_have = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         case (r_reg.aw_addr)
            A_CMD: r_next.cmd = merge(r_reg.cmd, r_reg.w_data, r_reg.w_strb) & 32'h000000FF;
            A_COUNT: r_next.count = merge(r_reg.count, r_reg.w_data, r_reg.w_strb);
            A_TAG: r_next.tag = merge(r_reg.tag, r_reg.w_data, r_reg.w_strb);
            A_LBA_LO: r_next.lba_lo = merge(r_reg.lba_lo, r_reg.w_data, r_reg.w_strb);
            A_LBA_HI: r_next.lba_hi = merge(r_reg.lba_hi, r_reg.w_data, r_reg.w_strb);
            A_ISSUE:
            begin
               // ignored while a frame is still waiting on the link
               if (!r_reg.h2d_valid)
               begin
                  r_next.h2d_valid = 1'b1;
                  r_next.h2d.cmd = r_reg.cmd[7:0];
                  r_next.h2d.feat_cur = {cnt16[7:5],
                                         r_reg.count[COUNT_SUB_LSB +: 5]};
                  r_next.h2d.feat_prev = cnt16[15:8];
                  r_next.h2d.cnt_cur = {r_reg.tag[TAG_W-1:0], 3'h0};
                  r_next.h2d.cnt_prev = 8'h00;
                  r_next.h2d.sn_cur = lba[7:0];
                  r_next.h2d.sn_prev = lba[31:24];
                  r_next.h2d.cl_cur = lba[15:8];
                  r_next.h2d.cl_prev = lba[39:32];
                  r_next.h2d.ch_cur = lba[23:16];
                  r_next.h2d.ch_prev = lba[47:40];
               end
            end
            A_DONE: r_next.done = r_reg.done & ~r_reg.w_data;
            A_RESULT: r_next.bresp = RESP_OKAY;
            default: r_next.bresp = RESP_SLVERR;
         endcase
      end
      // device frames; set after the clear so a completion is not lost
      if (lnk.d2h_valid)
      begin
         if (lnk.d2h.kind == FR_SDB)
         begin
            r_next.done = r_next.done | lnk.d2h.act;
         end
         else
         begin
            r_next.stat = lnk.d2h.status;
            r_next.err = lnk.d2h.error;
         end
      end
      if (r_reg.rvalid && s_rready)
      begin
         r_next.rvalid = 1'b0;
      end
      if (s_arvalid && !r_reg.rvalid)
      begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         case (s_araddr)
            A_CMD: r_next.rdata = r_reg.cmd;
            A_COUNT: r_next.rdata = r_reg.count;
            A_TAG: r_next.rdata = r_reg.tag;
            A_LBA_LO: r_next.rdata = r_reg.lba_lo;
            A_LBA_HI: r_next.rdata = r_reg.lba_hi;
            A_ISSUE: r_next.rdata = 32'h00000000;
            A_RESULT: r_next.rdata = {15'h0000, r_reg.h2d_valid, r_reg.err, r_reg.stat};
            A_DONE: r_next.rdata = r_reg.done;
            default:
            begin
               r_next.rdata = 32'h00000000;
               r_next.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_reg <= HOST_RESET;
      end
      else if (ce)
      begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign s_awready = !r_reg.aw_have;
   assign s_wready = !r_reg.w_have;
   assign s_bvalid = r_reg.bvalid;
   assign s_bresp = r_reg.bresp;
   assign s_arready = !r_reg.rvalid;
   assign s_rvalid = r_reg.rvalid;
   assign s_rdata = r_reg.rdata;
   assign s_rresp = r_reg.rresp;
   assign lnk.h2d_valid = r_reg.h2d_valid;
   assign lnk.h2d = r_reg.h2d;
   // frames are always consumed the cycle they appear
   assign lnk.d2h_ready = 1'b1;

endmodule
`default_nettype wire

// ---- bench/qsend_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsend_monitor
   import qsend_pkg::*;
(
   // clock, reset
   input wire logic aclk,
   input wire logic aresetn,
   // link signals
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire h2d_frame_t h2d,
   input wire logic d2h_valid,
   input wire logic d2h_ready,
   input wire d2h_frame_t d2h
);
   logic [TAGS-1:0] pend_reg, pend_next;
   logic [TAG_W-1:0] tag_reg, tag_next;
   logic take;
   assign take = h2d_valid && h2d_ready;
   // tags accepted and not yet reported; cleared only by a set-bits frame
   always_comb
   begin
      pend_next = pend_reg;
      tag_next = take ? h2d.cnt_cur[7:3] : tag_reg;
      if (d2h_valid && d2h_ready && d2h.kind == FR_SDB)
         pend_next = pend_next & ~d2h.act;
      if (d2h_valid && d2h_ready && d2h.kind == FR_REG && d2h.status == STAT_RDY)
         pend_next[tag_reg] = 1'b1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_reg <= '0;
         tag_reg <= '0;
      end
      else
      begin
         pend_reg <= pend_next;
         tag_reg <= tag_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reply_is_reg: assert property (take |=> d2h_valid && d2h.kind == FR_REG)
      else $error("no register frame after command");
   a_reply_single: assert property (take |=> d2h_valid ##1
      (!d2h_valid || d2h.kind == FR_SDB))
      else $error("register frame repeated");
   a_reg_needs_cmd: assert property (d2h_valid && d2h.kind == FR_REG |-> $past(take))
      else $error("register frame without command");
   a_opcode_abort: assert property (take && h2d.cmd != CMD_SEND_QUEUED |=>
      d2h.status == (STAT_RDY | STAT_ERR) && d2h.error == ERR_ABT)
      else $error("wrong opcode not aborted");
   a_sub_abort: assert property (take && h2d.feat_cur[SUB_MSB:0] != SUB_LOG_WRITE |=>
      d2h.status == (STAT_RDY | STAT_ERR) && d2h.error == ERR_ABT)
      else $error("reserved subcommand not aborted");
   a_accept_ok: assert property (take && h2d.cmd == CMD_SEND_QUEUED &&
      h2d.feat_cur[SUB_MSB:0] == SUB_LOG_WRITE && !pend_reg[h2d.cnt_cur[7:3]] |=>
      d2h.status == STAT_RDY && d2h.error == 8'h00)
      else $error("valid log write refused");
   a_sdb_status: assert property (d2h_valid && d2h.kind == FR_SDB |->
      d2h.status == STAT_RDY)
      else $error("set-bits frame status wrong");
   a_sdb_subset: assert property (d2h_valid && d2h.kind == FR_SDB |->
      d2h.act != '0 && (d2h.act & ~pend_reg) == '0)
      else $error("set-bits frame reports foreign tag");
   a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d))
      else $error("command frame changed while waiting");
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
   import qsend_pkg::*;
;
   localparam logic [15:0] CNT = 16'h1A42;
   localparam logic [47:0] LBA = 48'hA1B2C3D4E5F6;
   logic aclk, aresetn, wr_ready, wr_valid, done_valid;
   logic [TAG_W-1:0] done_tag;
   log_write_t wr_item;
   logic [7:0] command_error_flags, command_status_flags, s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rd;
   logic [3:0] s_wstrb;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   logic [1:0] s_bresp, s_rresp, resp;
   h2d_frame_t cap;
   logic [TAGS-1:0] sdb_acc;
   int fail_count, samples_checked, i;
   qsend_if qsend_if_i(.aclk(aclk));
   qsend_device qsend_device_i(.aclk, .aresetn, .ce(1'b1), .lnk(qsend_if_i), .wr_valid,
      .wr_ready, .wr_item, .done_valid, .done_tag, .command_error_flags, .command_status_flags);
   qsend_host qsend_host_i(.aclk, .aresetn, .ce(1'b1), .lnk(qsend_if_i), .s_awaddr, .s_awvalid,
      .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   qsend_monitor qsend_monitor_i(.aclk, .aresetn, .h2d_valid(qsend_if_i.h2d_valid),
      .h2d_ready(qsend_if_i.h2d_ready), .h2d(qsend_if_i.h2d), .d2h_valid(qsend_if_i.d2h_valid),
      .d2h_ready(qsend_if_i.d2h_ready), .d2h(qsend_if_i.d2h));
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // wire watch at negedge, where the link is settled
   always @(negedge aclk)
   begin
      if (qsend_if_i.h2d_valid && qsend_if_i.h2d_ready) cap <= qsend_if_i.h2d;
      if (qsend_if_i.d2h_valid && qsend_if_i.d2h.kind == FR_SDB)
      begin
         sdb_acc <= sdb_acc | qsend_if_i.d2h.act;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task end_sim;
   begin
      $display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task chk(input logic [71:0] g, input logic [71:0] e);
   begin
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   // handshakes judged at negedge: nothing the design drives moves there
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ka, kw, kb;
   begin
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      kb = 1'b0;
      while (!kb)
      begin
         @(negedge aclk);
         ka = s_awvalid && s_awready;
         kw = s_wvalid && s_wready;
         kb = s_bvalid;
         resp = s_bresp;
         @(posedge aclk);
         if (ka) s_awvalid <= 1'b0;
         if (kw) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
   end
   endtask
   task rdr(input logic [7:0] a);
      logic ka, kr;
   begin
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      kr = 1'b0;
      while (!kr)
      begin
         @(negedge aclk);
         ka = s_arvalid && s_arready;
         kr = s_rvalid;
         rd = s_rdata;
         resp = s_rresp;
         @(posedge aclk);
         if (ka) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
   end
   endtask
   task send(input logic [4:0] t, input logic [4:0] s, input bit w);
   begin
      wr(A_COUNT, {11'h000, s, CNT});
      wr(A_TAG, {27'h0, t});
      wr(A_LBA_LO, LBA[31:0]);
      wr(A_LBA_HI, {16'h0000, LBA[47:32]});
      wr(A_ISSUE, 32'h00000001);
      rd = 32'h00010000;
      while (w && rd[RESULT_BUSY_BIT]) rdr(A_RESULT);
   end
   endtask
   task pop(input logic [4:0] t);
   begin
      @(negedge aclk);
      chk({wr_valid, wr_item.tag, wr_item.count, wr_item.lba}, {1'b1, t, CNT, LBA});
      @(posedge aclk);
      wr_ready <= 1'b1;
      @(posedge aclk);
      wr_ready <= 1'b0;
   end
   endtask
   initial
   begin
      #400000;
      fail_count++;
      end_sim();
   end
   initial
   begin
      {aresetn, wr_ready, done_valid, done_tag, s_awaddr, s_araddr, s_wdata} = '0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      s_wstrb = 4'hF;
      sdb_acc = '0;
      fail_count = 0;
      samples_checked = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(A_CMD);
      chk(rd, 32'h00000064);
      chk({command_status_flags, command_error_flags}, {FLAGS_RESET, FLAGS_RESET});
      rdr(8'h40);
      chk(resp, RESP_SLVERR);
      wr(8'h40, 32'h00000000);
      chk(resp, RESP_SLVERR);
      send(5'h03, SUB_LOG_WRITE, 1'b1);
      chk(rd[15:0], 16'h0040);
      chk({cap.cmd, cap.feat_cur[4:0]}, {CMD_SEND_QUEUED, SUB_LOG_WRITE});
      chk(cap.cnt_cur[7:3], 5'h03);
      chk({cap.feat_prev, cap.feat_cur}, CNT);
      chk({cap.sn_cur, cap.sn_prev}, {LBA[7:0], LBA[31:24]});
      chk({cap.cl_cur, cap.cl_prev}, {LBA[15:8], LBA[39:32]});
      chk({cap.ch_cur, cap.ch_prev}, {LBA[23:16], LBA[47:40]});
      chk({command_status_flags, command_error_flags}, {STAT_RDY, 8'h00});
      send(5'h03, SUB_LOG_WRITE, 1'b1);
      chk(rd[15:0], 16'h0441);
      send(5'h09, SUB_LOG_WRITE, 1'b1);
      chk(rd[15:0], 16'h0040);
      // buffer full: third command must wait, not vanish
      send(5'h0A, SUB_LOG_WRITE, 1'b0);
      repeat (8) @(posedge aclk);
      rdr(A_RESULT);
      chk(rd[RESULT_BUSY_BIT], 1'b1);
      pop(5'h03);
      pop(5'h09);
      while (rd[RESULT_BUSY_BIT]) rdr(A_RESULT);
      chk(rd[15:0], 16'h0040);
      pop(5'h0A);
      for (i = 0; i < 32; i++)
      begin
         if (i != 2) send(5'h14, i[4:0], 1'b1);
         if (i != 2) chk(rd[15:0], 16'h0441);
      end
      chk(wr_valid, 1'b0);
      wr(A_CMD, 32'h00000065);
      send(5'h15, SUB_LOG_WRITE, 1'b1);
      chk({command_status_flags, command_error_flags}, 16'h4104);
      wr(A_CMD, 32'h00000064);
      @(posedge aclk);
      done_valid <= 1'b1;
      done_tag <= 5'h03;
      @(posedge aclk);
      done_tag <= 5'h09;
      @(posedge aclk);
      done_tag <= 5'h1E;
      @(posedge aclk);
      done_valid <= 1'b0;
      repeat (10) @(posedge aclk);
      chk(sdb_acc, 32'h00000208);
      rdr(A_DONE);
      chk(rd, 32'h00000208);
      wr(A_DONE, 32'h00000208);
      rdr(A_DONE);
      chk(rd, 32'h00000000);
      send(5'h03, SUB_LOG_WRITE, 1'b1);
      chk(rd[15:0], 16'h0040);
      // byte strobes: only the low byte of the tag register may change
      s_wstrb <= 4'h1;
      wr(A_TAG, 32'hFFFFFF1F);
      chk(resp, RESP_OKAY);
      s_wstrb <= 4'hF;
      rdr(A_TAG);
      chk(rd, 32'h0000001F);
      end_sim();
   end
endmodule
`default_nettype wire
